// [rfis_pkg.sv]
// shared constants, types and register map of the reset flags and init-state block
package rfis_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RELEASE_DELAY_NS = 100000000;
  localparam int CNT_W = 20;
  typedef logic [CNT_W-1:0] rfis_cnt_t;
  // least time, so round up to whole cycles
  localparam rfis_cnt_t RELEASE_CYCLES =
    rfis_cnt_t'((RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam rfis_cnt_t STARTUP_LONG_CYCLES = 20'h00400;
  localparam rfis_cnt_t STARTUP_SHORT_CYCLES = 20'h00002;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENT = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hC;

  // ctrl fields
  localparam int CTRL_SHORT_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam logic CTRL_SHORT_RST = 1'h0;

  // oscillator source codes held in ctrl
  typedef enum logic [1:0] {
    SRC_EXT_RC = 2'h0,
    SRC_INT_FAST_RC = 2'h1,
    SRC_EXT_FAST_XTAL = 2'h2,
    SRC_EXT_SLOW_XTAL = 2'h3
  } rfis_src_e;

  // status fields
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_POWERDOWN_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_CORE_RST_BIT = 3;

  // event bits, shared by event and mask registers
  localparam int EV_W = 4;
  localparam int EV_PIN_LV_RESET = 0;
  localparam int EV_WDT_RESET = 1;
  localparam int EV_WDT_WAKE = 2;
  localparam int EV_PIN_WAKE = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // ------------------------------------------------------------------
  // sequencer states, gray along hold-release-run-sleep-wake
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_RELEASE = 3'h1,
    ST_RUN = 3'h3,
    ST_SLEEP = 3'h2,
    ST_WAKE = 3'h6
  } rfis_state_e;

endpackage

// [rfis_delay_timer.sv]
// down counter that times the release delay and the start-up delay
`timescale 1ns/1ps
module rfis_delay_timer (
  input wire logic clock_in,                     // system clock
  input wire logic rstn_in,                      // async reset, active low
  input wire logic load_in,                      // start a new delay
  input wire rfis_pkg::rfis_cnt_t cycles_in,     // delay length in cycles, at least 1
  output logic done_out                          // high in the last cycle of the delay
);

  typedef struct packed {
    logic busy;
    rfis_pkg::rfis_cnt_t cnt;
  } rfis_tmr_s;

  rfis_tmr_s s_q;
  rfis_tmr_s s_d;

  assign done_out = s_q.busy && (s_q.cnt == '0) && !load_in;

  always_comb begin
    s_d = s_q;
    if (load_in) begin
      s_d.busy = 1'b1;
      s_d.cnt = cycles_in - rfis_pkg::rfis_cnt_t'(1);
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - rfis_pkg::rfis_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // rfis_delay_timer

// [rfis_reset_ctrl.sv]
// reset sequencer: reset-cause flags, init-state strobes, start-up timing, register slave
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
module rfis_reset_ctrl #(
  parameter rfis_pkg::rfis_cnt_t RELEASE_CYCLES = rfis_pkg::RELEASE_CYCLES
) (
  input wire logic clock_in,              // system clock, 10 MHz
  input wire logic rstn_in,               // power-on reset, async, active low
  input wire logic ext_reset_n_in,        // external reset pin, active low
  input wire logic low_voltage_reset_in,  // supply monitor reset request
  input wire logic watchdog_timeout_in,   // watchdog expiry pulse
  input wire logic halt_in,               // core enters idle or sleep
  input wire logic wake_pin_in,           // pin wake-up request while asleep
  input wire logic clear_watchdog_in,     // core clears the watchdog
  input wire logic [3:0] address,         // avalon byte address
  input wire logic read,                  // avalon read
  input wire logic write,                 // avalon write
  input wire logic [3:0] byteenable,      // avalon byte enables
  input wire logic [31:0] writedata,      // avalon write data
  output logic [31:0] readdata,           // avalon read data
  output logic waitrequest,               // avalon wait
  output logic irq_out,                   // level interrupt
  output logic core_reset_out,            // core held in reset
  output logic pc_stack_clear_out,        // clear pc low byte and stack pointer
  output logic periph_reset_out,          // full reset of peripheral state
  output logic intr_disable_out,          // clear all interrupt enables
  output logic timer_stop_out,            // stop timer counters
  output logic prescaler_clear_out,       // clear timer prescaler
  output logic port_init_out,             // load ones into port data and direction
  output logic watchdog_clear_out,        // hold watchdog counter at zero
  output logic sleep_out,                 // device is idle or asleep
  output logic watchdog_timeout_flag_out, // timeout flag
  output logic powerdown_flag_out         // powerdown flag
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    rfis_pkg::rfis_state_e st;
    logic to_flag;
    logic pd_flag;
    logic wdt_wake;
    logic short_sel;
    rfis_pkg::rfis_src_e src;
    logic [rfis_pkg::EV_W-1:0] events;
    logic [rfis_pkg::EV_W-1:0] mask;
    logic ack;
    logic [31:0] rdata;
  } rfis_ctrl_s;

  rfis_ctrl_s s_q;
  rfis_ctrl_s s_d;

  logic tmr_load;
  rfis_pkg::rfis_cnt_t tmr_cycles;
  logic tmr_done;
  logic src_active;
  logic is_rc;
  rfis_pkg::rfis_cnt_t startup_cycles;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [rfis_pkg::EV_W-1:0] ev_set;
  logic [31:0] status_word;

  // ------------------------------------------------------------------
  // delay timer
  // ------------------------------------------------------------------
  rfis_delay_timer u_timer (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .load_in(tmr_load),
    .cycles_in(tmr_cycles),
    .done_out(tmr_done)
  );

  assign src_active = !ext_reset_n_in || low_voltage_reset_in;
  assign is_rc = (s_q.src == rfis_pkg::SRC_EXT_RC) || (s_q.src == rfis_pkg::SRC_INT_FAST_RC);
  // crystals ignore the short setting, they need the full settling time
  assign startup_cycles = (is_rc && s_q.short_sel) ? rfis_pkg::STARTUP_SHORT_CYCLES
                                                   : rfis_pkg::STARTUP_LONG_CYCLES;

  // ------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second edge
  // ------------------------------------------------------------------
  assign bus_req = (read || write) && !s_q.ack;
  assign waitrequest = (read || write) && !s_q.ack;
  assign bus_wr = write && s_q.ack && byteenable[0];
  assign bus_rd = read && s_q.ack;
  assign readdata = s_q.rdata;

  always_comb begin
    status_word = '0;
    status_word[rfis_pkg::STAT_TIMEOUT_BIT] = s_q.to_flag;
    status_word[rfis_pkg::STAT_POWERDOWN_BIT] = s_q.pd_flag;
    status_word[rfis_pkg::STAT_SLEEP_BIT] = (s_q.st == rfis_pkg::ST_SLEEP);
    status_word[rfis_pkg::STAT_CORE_RST_BIT] = core_reset_out;
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_cycles = RELEASE_CYCLES;
    ev_set = '0;
    unique case (s_q.st)
      rfis_pkg::ST_HOLD: begin
        if (!src_active) begin
          s_d.st = rfis_pkg::ST_RELEASE;
          tmr_load = 1'b1;
        end
      end
      rfis_pkg::ST_RELEASE: begin
        if (src_active) begin
          s_d.st = rfis_pkg::ST_HOLD;
        end else if (tmr_done) begin
          s_d.st = rfis_pkg::ST_RUN;
        end
      end
      rfis_pkg::ST_RUN: begin
        if (src_active) begin
          // flags left alone
          s_d.st = rfis_pkg::ST_HOLD;
          ev_set[rfis_pkg::EV_PIN_LV_RESET] = 1'b1;
        end else if (watchdog_timeout_in) begin
          // same path as a pin reset, plus the timeout flag
          s_d.st = rfis_pkg::ST_HOLD;
          s_d.to_flag = 1'b1;
          ev_set[rfis_pkg::EV_WDT_RESET] = 1'b1;
        end else if (halt_in) begin
          s_d.st = rfis_pkg::ST_SLEEP;
          s_d.pd_flag = 1'b1;
          s_d.to_flag = 1'b0;
        end else if (clear_watchdog_in) begin
          s_d.pd_flag = 1'b0;
          s_d.to_flag = 1'b0;
        end
      end
      rfis_pkg::ST_SLEEP: begin
        if (src_active) begin
          s_d.st = rfis_pkg::ST_HOLD;
          ev_set[rfis_pkg::EV_PIN_LV_RESET] = 1'b1;
        end else if (watchdog_timeout_in) begin
          // wake only; powerdown flag stays set from sleep entry
          s_d.st = rfis_pkg::ST_WAKE;
          s_d.to_flag = 1'b1;
          s_d.wdt_wake = 1'b1;
          tmr_load = 1'b1;
          tmr_cycles = startup_cycles;
          ev_set[rfis_pkg::EV_WDT_WAKE] = 1'b1;
        end else if (wake_pin_in) begin
          s_d.st = rfis_pkg::ST_WAKE;
          s_d.wdt_wake = 1'b0;
          tmr_load = 1'b1;
          tmr_cycles = startup_cycles;
          ev_set[rfis_pkg::EV_PIN_WAKE] = 1'b1;
        end
      end
      rfis_pkg::ST_WAKE: begin
        if (src_active) begin
          s_d.st = rfis_pkg::ST_HOLD;
          s_d.wdt_wake = 1'b0;
          ev_set[rfis_pkg::EV_PIN_LV_RESET] = 1'b1;
        end else if (tmr_done) begin
          s_d.st = rfis_pkg::ST_RUN;
          s_d.wdt_wake = 1'b0;
        end
      end
      default: begin
        s_d.st = rfis_pkg::ST_HOLD;
      end
    endcase

    // register bus
    s_d.ack = bus_req;
    if (bus_req) begin
      unique case (address)
        rfis_pkg::ADDR_CTRL: begin
          s_d.rdata = {29'h0, s_q.src, s_q.short_sel};
        end
        rfis_pkg::ADDR_STATUS: begin
          s_d.rdata = status_word;
        end
        rfis_pkg::ADDR_EVENT: begin
          s_d.rdata = {28'h0, s_q.events};
        end
        rfis_pkg::ADDR_MASK: begin
          s_d.rdata = {28'h0, s_q.mask};
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
    if (bus_wr && address == rfis_pkg::ADDR_CTRL) begin
      s_d.short_sel = writedata[rfis_pkg::CTRL_SHORT_BIT];
      s_d.src = rfis_pkg::rfis_src_e'(writedata[rfis_pkg::CTRL_SRC_LSB +: 2]);
    end
    if (bus_wr && address == rfis_pkg::ADDR_MASK) begin
      s_d.mask = writedata[rfis_pkg::EV_W-1:0];
    end
    // a read clears the events; a new event in the same cycle survives
    if (bus_rd && address == rfis_pkg::ADDR_EVENT) begin
      s_d.events = ev_set;
    end else begin
      s_d.events = s_q.events | ev_set;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q.st <= rfis_pkg::ST_HOLD;
      s_q.to_flag <= 1'b0;
      s_q.pd_flag <= 1'b0;
      s_q.wdt_wake <= 1'b0;
      s_q.short_sel <= rfis_pkg::CTRL_SHORT_RST;
      s_q.src <= rfis_pkg::SRC_EXT_RC;
      s_q.events <= rfis_pkg::EV_RST;
      s_q.mask <= rfis_pkg::MASK_RST;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // init-state strobes
  // ------------------------------------------------------------------
  // every full reset passes hold and release, so these cover power-on too
  assign core_reset_out = (s_q.st == rfis_pkg::ST_HOLD) || (s_q.st == rfis_pkg::ST_RELEASE);
  assign periph_reset_out = core_reset_out;
  assign intr_disable_out = core_reset_out;
  assign timer_stop_out = core_reset_out;
  assign prescaler_clear_out = core_reset_out;
  assign port_init_out = core_reset_out;
  // pc and stack clear is the only init strobe raised by a watchdog wake
  assign pc_stack_clear_out = core_reset_out ||
    ((s_q.st == rfis_pkg::ST_WAKE) && s_q.wdt_wake);
  // counter held clear during reset, free to count from the first run cycle
  assign watchdog_clear_out = core_reset_out;
  assign sleep_out = (s_q.st == rfis_pkg::ST_SLEEP);
  assign watchdog_timeout_flag_out = s_q.to_flag;
  assign powerdown_flag_out = s_q.pd_flag;
  assign irq_out = |(s_q.events & s_q.mask);

endmodule // rfis_reset_ctrl

// [rfis_reset_ctrl_asserts.sv]
// checker of reset sequencing, init strobes and reset-cause flags
`timescale 1ns/1ps
module rfis_reset_ctrl_asserts #(
  parameter rfis_pkg::rfis_cnt_t RELEASE_CYCLES = rfis_pkg::RELEASE_CYCLES
) (
  input wire logic clock_in,                  // system clock
  input wire logic rstn_in,                   // async reset, active low
  input wire logic ext_reset_n_in,            // reset pin, active low
  input wire logic low_voltage_reset_in,      // supply monitor reset
  input wire logic watchdog_timeout_in,       // watchdog expiry
  input wire logic halt_in,                   // core enters sleep
  input wire logic core_reset_out,            // core held in reset
  input wire logic pc_stack_clear_out,        // pc and stack clear
  input wire logic periph_reset_out,          // peripheral reset
  input wire logic intr_disable_out,          // interrupt enables clear
  input wire logic timer_stop_out,            // timers stopped
  input wire logic prescaler_clear_out,       // prescaler clear
  input wire logic port_init_out,             // ports to inputs
  input wire logic watchdog_clear_out,        // watchdog held clear
  input wire logic sleep_out,                 // asleep
  input wire logic watchdog_timeout_flag_out, // timeout flag
  input wire logic powerdown_flag_out         // powerdown flag
);
  // ------------------------------------------------------------------
  // helpers: cycles held in reset with no source active, and cycles spent in a watchdog wake
  // ------------------------------------------------------------------
  logic idle;
  rfis_pkg::rfis_cnt_t hold_cnt_q;
  rfis_pkg::rfis_cnt_t wake_cnt_q;
  // start-up delay is too long for a delay range, so it is counted here
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_cnt_q <= 20'h00000;
    end else if (pc_stack_clear_out && !core_reset_out) begin
      wake_cnt_q <= wake_cnt_q + 20'h00001;
    end else begin
      wake_cnt_q <= 20'h00000;
    end
  end
  assign idle = ext_reset_n_in && !low_voltage_reset_in;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_cnt_q <= 20'h00000;
    end else if (core_reset_out && idle) begin
      hold_cnt_q <= hold_cnt_q + 20'h00001;
    end else begin
      hold_cnt_q <= 20'h00000;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  AST_STROBES: assert property (
    {periph_reset_out, intr_disable_out, timer_stop_out, prescaler_clear_out,
     port_init_out, watchdog_clear_out} == {6{core_reset_out}})
    else $error("init strobes differ from core reset");
  AST_PC_CLEAR: assert property (core_reset_out |-> pc_stack_clear_out)
    else $error("pc and stack not cleared in reset");
  AST_RELEASE: assert property (
    $fell(core_reset_out) |-> hold_cnt_q == RELEASE_CYCLES + 20'h00001)
    else $error("release delay has wrong length");
  AST_PIN_LV: assert property (
    !core_reset_out && !pc_stack_clear_out && !idle |=> core_reset_out
      && $stable(watchdog_timeout_flag_out) && $stable(powerdown_flag_out))
    else $error("pin or low voltage reset mishandled");
  AST_WDT_RUN: assert property (
    !core_reset_out && !sleep_out && !pc_stack_clear_out && idle && watchdog_timeout_in
      |=> core_reset_out && watchdog_timeout_flag_out && $stable(powerdown_flag_out))
    else $error("watchdog reset in run mishandled");
  AST_WDT_SLEEP: assert property (
    sleep_out && idle && watchdog_timeout_in |=> pc_stack_clear_out && !core_reset_out
      && watchdog_timeout_flag_out && powerdown_flag_out)
    else $error("watchdog wake from sleep mishandled");
  AST_STARTUP: assert property (
    $fell(pc_stack_clear_out) && !core_reset_out && wake_cnt_q != 20'h00000
      |-> wake_cnt_q == rfis_pkg::STARTUP_SHORT_CYCLES
        || wake_cnt_q == rfis_pkg::STARTUP_LONG_CYCLES)
    else $error("start-up delay out of range");
  AST_SLEEP_ENTRY: assert property (
    halt_in && !watchdog_timeout_in && idle && !core_reset_out && !sleep_out
      && !pc_stack_clear_out |=> sleep_out && powerdown_flag_out && !watchdog_timeout_flag_out)
    else $error("sleep entry flags wrong");
endmodule // rfis_reset_ctrl_asserts

bind rfis_reset_ctrl rfis_reset_ctrl_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .ext_reset_n_in(ext_reset_n_in),
  .low_voltage_reset_in(low_voltage_reset_in), .watchdog_timeout_in(watchdog_timeout_in),
  .halt_in(halt_in), .core_reset_out(core_reset_out), .pc_stack_clear_out(pc_stack_clear_out),
  .periph_reset_out(periph_reset_out), .intr_disable_out(intr_disable_out),
  .timer_stop_out(timer_stop_out), .prescaler_clear_out(prescaler_clear_out),
  .port_init_out(port_init_out), .watchdog_clear_out(watchdog_clear_out),
  .sleep_out(sleep_out), .watchdog_timeout_flag_out(watchdog_timeout_flag_out),
  .powerdown_flag_out(powerdown_flag_out));

// [rfis_wdt_model.sv]
// behavioural watchdog: counts while not held clear, expires on bench command
`timescale 1ns/1ps
module rfis_wdt_model (
  input wire logic clock_in,      // system clock
  input wire logic rstn_in,       // async reset, active low
  input wire logic hold_clear_in, // counter held at zero
  input wire logic fire_in,       // bench asks for an expiry
  output logic expiry_out,        // one-cycle expiry pulse
  output logic [15:0] count_out   // cycles since last clear
);
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      expiry_out <= 1'h0;
      count_out <= 16'h0000;
    end else begin
      // a pulse, since a lingering level would re-trigger after wake
      expiry_out <= fire_in;
      count_out <= hold_clear_in ? 16'h0000 : count_out + 16'h0001;
    end
  end
endmodule // rfis_wdt_model

// [tb.sv]
// self-checking bench of the reset sequencer
`timescale 1ns/1ps
module tb;
  logic clock_in = 1'b0, rstn_in = 1'b0, ext_reset_n_in = 1'b1, low_voltage_reset_in = 1'b0;
  logic halt_in = 1'b0, wake_pin_in = 1'b0, clear_watchdog_in = 1'b0, fire = 1'b0;
  logic read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h00000000, readdata, rd;
  logic waitrequest, irq_out, core_reset_out, pc_stack_clear_out, periph_reset_out;
  logic intr_disable_out, timer_stop_out, prescaler_clear_out, port_init_out, sleep_out;
  logic watchdog_clear_out, watchdog_timeout_flag_out, powerdown_flag_out, watchdog_timeout_in;
  logic [15:0] wdt_count;
  int mismatches = 0, checked = 0, n;
  logic [3:0] cfg [5] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7};
  int exp_start [5] = '{1024, 2, 2, 1024, 1024};
  always #50 clock_in = ~clock_in;
  rfis_reset_ctrl #(.RELEASE_CYCLES(20'h00008)) u_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .ext_reset_n_in(ext_reset_n_in),
    .low_voltage_reset_in(low_voltage_reset_in), .watchdog_timeout_in(watchdog_timeout_in),
    .halt_in(halt_in), .wake_pin_in(wake_pin_in), .clear_watchdog_in(clear_watchdog_in),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq_out(irq_out),
    .core_reset_out(core_reset_out), .pc_stack_clear_out(pc_stack_clear_out),
    .periph_reset_out(periph_reset_out), .intr_disable_out(intr_disable_out),
    .timer_stop_out(timer_stop_out), .prescaler_clear_out(prescaler_clear_out),
    .port_init_out(port_init_out), .watchdog_clear_out(watchdog_clear_out),
    .sleep_out(sleep_out), .watchdog_timeout_flag_out(watchdog_timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out));
  rfis_wdt_model u_wdt (.clock_in(clock_in), .rstn_in(rstn_in),
    .hold_clear_in(watchdog_clear_out), .fire_in(fire), .expiry_out(watchdog_timeout_in),
    .count_out(wdt_count));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task chk_count(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task limit(input int k, input int lim);
    if (k >= lim) begin
      mismatches++;
      complete_run();
    end
  endtask
  task chk_flags(input logic [1:0] e);
    chk_word("flags", {30'h0, e}, {30'h0, powerdown_flag_out, watchdog_timeout_flag_out});
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    @(posedge clock_in);
    {read, write, address, writedata, byteenable} <= {!wr, wr, a, d, be};
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    limit(k, 50);
    // read data stand at the completing edge, where they are taken
    rd = readdata;
    {read, write} <= 2'h0;
    // let the write land before callers look at outputs
    @(negedge clock_in);
  endtask
  task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, 4'hF);
    chk_word(nm, e, rd);
  endtask
  // one-cycle pulse: 0 halt, 1 clear watchdog, 2 wake pin, 3 watchdog expiry
  task pulse(input int s);
    @(posedge clock_in);
    {fire, wake_pin_in, clear_watchdog_in, halt_in} <= 4'h1 << s;
    @(posedge clock_in);
    {fire, wake_pin_in, clear_watchdog_in, halt_in} <= 4'h0;
    repeat (2) @(negedge clock_in);
  endtask
  task run_wait();
    n = 0;
    while ((core_reset_out !== 1'b0 || pc_stack_clear_out !== 1'b0) && n < 3000) begin
      @(negedge clock_in);
      n++;
    end
    limit(n, 3000);
  endtask
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    #5000000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clock_in);
    chk_flags(2'h0);
    chk_word("strobes", 32'h7F, {25'h0, core_reset_out, pc_stack_clear_out, periph_reset_out,
      intr_disable_out, timer_stop_out, prescaler_clear_out, port_init_out});
    rstn_in <= 1'b1;
    run_wait();
    repeat (5) @(negedge clock_in);
    chk_count("watchdog count", 5, int'(wdt_count));
    rd_chk("ctrl", rfis_pkg::ADDR_CTRL, 32'h0);
    rd_chk("status", rfis_pkg::ADDR_STATUS, 32'h0);
    bus(1'b1, rfis_pkg::ADDR_MASK, 32'hF, 4'h0);
    rd_chk("mask", rfis_pkg::ADDR_MASK, 32'h0);
    bus(1'b1, rfis_pkg::ADDR_MASK, 32'hF, 4'hF);
    rd_chk("mask", rfis_pkg::ADDR_MASK, 32'hF);
    bus(1'b1, 4'h2, 32'hF, 4'hF);
    rd_chk("unmapped", 4'h2, 32'h0);
    bus(1'b1, rfis_pkg::ADDR_STATUS, 32'h3, 4'hF);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, rfis_pkg::ADDR_CTRL, {28'h0, cfg[i]}, 4'hF);
      pulse(0);
      rd_chk("status", rfis_pkg::ADDR_STATUS, 32'h6);
      pulse(3);
      n = 0;
      while (pc_stack_clear_out === 1'b1 && core_reset_out === 1'b0 && n < 2000) begin
        @(negedge clock_in);
        n++;
      end
      chk_count("start-up", exp_start[i], n);
      chk_flags(2'h3);
      chk_word("irq", 32'h1, {31'h0, irq_out});
      rd_chk("event", rfis_pkg::ADDR_EVENT, 32'h4);
    end
    pulse(0);
    pulse(2);
    chk_word("pc clear", 32'h0, {31'h0, pc_stack_clear_out});
    // pin wake shows on no strobe, so sit out the long start-up delay
    repeat (1030) @(negedge clock_in);
    run_wait();
    rd_chk("event", rfis_pkg::ADDR_EVENT, 32'h8);
    bus(1'b1, rfis_pkg::ADDR_MASK, 32'h0, 4'hF);
    pulse(3);
    chk_word("core reset", 32'h1, {31'h0, core_reset_out});
    chk_flags(2'h3);
    run_wait();
    chk_word("irq", 32'h0, {31'h0, irq_out});
    bus(1'b1, rfis_pkg::ADDR_MASK, 32'h2, 4'hF);
    chk_word("irq", 32'h1, {31'h0, irq_out});
    rd_chk("event", rfis_pkg::ADDR_EVENT, 32'h2);
    chk_word("irq", 32'h0, {31'h0, irq_out});
    pulse(1);
    chk_flags(2'h0);
    pulse(3);
    run_wait();
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      {ext_reset_n_in, low_voltage_reset_in} <= (k == 0) ? 2'h0 : 2'h3;
      repeat (3) @(negedge clock_in);
      chk_word("core reset", 32'h1, {31'h0, core_reset_out});
      @(posedge clock_in);
      {ext_reset_n_in, low_voltage_reset_in} <= 2'h2;
      run_wait();
      chk_flags(2'h1);
    end
    rd_chk("event", rfis_pkg::ADDR_EVENT, 32'h3);
    complete_run();
  end
endmodule // tb
